// ### hw/ulp_phy_port.sv
/*
  Transceiver side of the 12-pin interface: synchronous and low-power modes.
  Assumes the link on the far side keeps to the bus protocol, and that the
  receive, status and register paths of the transceiver core feed it.
*/
`timescale 1ns/1ps
module ulp_phy_port (
  // system
  input wire logic clock,
  input wire logic reset,
  // oscillator and interface clock
  input wire logic osc_present,
  output logic ulpi_clock_out,
  // interface pins
  input wire logic [ulp_pkg::DATA_W-1:0] ulpi_data_in,
  output logic [ulp_pkg::DATA_W-1:0] ulpi_data_out,
  output logic ulpi_data_oe_n,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  input wire logic ulpi_stp,
  // analog receiver and interrupt sources
  input wire logic [1:0] line_state,
  input wire logic [ulp_pkg::INT_SRC_W-1:0] int_sources,
  input wire logic [ulp_pkg::INT_SRC_W-1:0] int_enable,
  // received usb data
  input wire logic rx_active,
  input wire logic rx_valid,
  input wire logic [ulp_pkg::DATA_W-1:0] rx_data,
  output logic rx_taken,
  // status bytes
  input wire logic rxcmd_req,
  input wire logic [ulp_pkg::DATA_W-1:0] rxcmd_byte,
  output logic rxcmd_taken,
  // register read data
  input wire logic rd_valid,
  input wire logic [ulp_pkg::DATA_W-1:0] rd_data,
  output logic rd_taken,
  // bytes from the link
  input wire logic tx_ready,
  output logic tx_valid,
  output logic tx_first,
  output logic [ulp_pkg::DATA_W-1:0] tx_byte,
  output logic tx_done,
  // suspend control
  input wire logic suspend_bar_bit,
  output logic suspend_exit,
  output logic sync_mode
);
  import ulp_pkg::*;

  ulp_lp_if lp ();

  ulp_lowpower u_lowpower (
    .clock(clock),
    .reset(reset),
    .line_state(line_state),
    .int_sources(int_sources),
    .int_enable(int_enable),
    .lp(lp)
  );

  // pin synchronisers
  logic osc_meta;
  logic osc_s;
  logic stp_meta;
  logic stp_s;
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_s;

  always_ff @(posedge clock) begin
    if (reset) begin
      osc_meta <= 1'b0;
      osc_s <= 1'b0;
      stp_meta <= 1'b0;
      stp_s <= 1'b0;
      data_meta <= DATA_RESET;
      data_s <= DATA_RESET;
    end else begin
      osc_meta <= osc_present;
      osc_s <= osc_meta;
      stp_meta <= ulpi_stp;
      stp_s <= stp_meta;
      data_meta <= ulpi_data_in;
      data_s <= data_meta;
    end
  end

  // interface clock divider; an integer divide cannot hit the rate exactly
  logic [3:0] div_cnt;
  logic clk_out;

  wire div_wrap = (div_cnt == CLK_DIV_HALF - 4'h1);
  wire tick = osc_s & div_wrap & ~clk_out;

  always_ff @(posedge clock) begin
    if (reset) begin
      div_cnt <= DIV_RESET;
      clk_out <= 1'b0;
    end else if (!osc_s) begin
      div_cnt <= DIV_RESET;
      clk_out <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? DIV_RESET : div_cnt + 4'h1;
      clk_out <= div_wrap ? ~clk_out : clk_out;
    end
  end

  assign ulpi_clock_out = clk_out;

  // port state
  ulp_state_t state;
  ulp_state_t next_state;
  logic [7:0] settle_cnt;
  logic [1:0] turn_cnt;
  logic dir;
  logic nxt;
  logic [DATA_W-1:0] data_reg;
  logic wake_rxcmd;

  // what is waiting for the link, register data first
  wire have_byte = rd_valid | rx_valid | rxcmd_req | wake_rxcmd | rx_active;
  wire txcmd_seen = (data_s != TXCMD_NONE);
  wire settled = (settle_cnt == CLK_STABLE_TICKS);
  wire turn_done = (turn_cnt == TURN_TICKS - 2'h1);
  wire sel_rd = rd_valid;
  wire sel_rx = ~rd_valid & rx_valid;
  wire sel_cmd = ~rd_valid & ~rx_valid & (rxcmd_req | wake_rxcmd);
  wire send_any = sel_rd | sel_rx | sel_cmd;
  wire [DATA_W-1:0] send_byte = sel_rd ? rd_data : (sel_rx ? rx_data : rxcmd_byte);
  wire in_lp = (state == ST_LOWPOWER);
  wire lp_wake = in_lp & tick & stp_s;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_POWERUP: begin
        if (settled) begin
          next_state = ST_TURN_DN;
        end
      end
      ST_IDLE: begin
        if (txcmd_seen) begin
          next_state = ST_LINK_TX;
        end else if (!suspend_bar_bit) begin
          next_state = ST_TURN_UP;
        end else if (have_byte) begin
          next_state = ST_TURN_UP;
        end
      end
      ST_LINK_TX: begin
        if (stp_s) begin
          next_state = ST_IDLE;
        end
      end
      ST_TURN_UP: begin
        if (turn_done) begin
          next_state = suspend_bar_bit ? ST_SEND : ST_LOWPOWER;
        end
      end
      ST_SEND: begin
        if (stp_s) begin
          next_state = ST_TURN_DN;
        end else if (!send_any && !rx_active) begin
          next_state = ST_TURN_DN;
        end
      end
      ST_TURN_DN: begin
        if (turn_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_LOWPOWER: begin
        if (stp_s) begin
          next_state = ST_TURN_DN;
        end
      end
      default: begin
        next_state = ST_POWERUP;
      end
    endcase
  end

  // first byte goes out on the tick that ends the turnaround, so no empty status slot
  wire send_slot = (state == ST_SEND) | ((state == ST_TURN_UP) & turn_done & suspend_bar_bit);
  wire entering_send = send_slot & ~stp_s & send_any;
  wire entering_lp = (state == ST_TURN_UP) & turn_done & ~suspend_bar_bit;
  wire link_byte = (state == ST_LINK_TX) & ~stp_s & nxt;
  wire idle_txcmd = (state == ST_IDLE) & txcmd_seen;
  // direction high in power-up, on the way up, sending and in low-power
  wire next_dir = (next_state == ST_POWERUP) | (next_state == ST_TURN_UP) |
                  (next_state == ST_SEND) | (next_state == ST_LOWPOWER);

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= ST_POWERUP;
      settle_cnt <= 8'h00;
      turn_cnt <= 2'h0;
      dir <= DIR_RESET;
      nxt <= NXT_RESET;
      data_reg <= DATA_RESET;
    end else if (tick) begin
      state <= next_state;
      if (state == ST_POWERUP && !settled) begin
        settle_cnt <= settle_cnt + 8'h01;
      end
      turn_cnt <= (next_state == state) ? turn_cnt + 2'h1 : 2'h0;
      dir <= next_dir;
      if (next_state == ST_LINK_TX) begin
        nxt <= tx_ready;
      end else if (entering_send) begin
        nxt <= sel_rx;
      end else begin
        nxt <= 1'b0;
      end
      data_reg <= entering_send ? send_byte : DATA_RESET;
    end
  end

  // wake-up status flag: set after leaving low power if an interrupt source changed and still differs, set wins over clear
  always_ff @(posedge clock) begin
    if (reset) begin
      wake_rxcmd <= 1'b0;
    end else if (lp.wake_rxcmd) begin
      wake_rxcmd <= 1'b1;
    end else if (tick && entering_send && sel_cmd) begin
      wake_rxcmd <= 1'b0;
    end
  end

  // one-cycle strobes toward the core, with tx_byte held between them
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_taken <= 1'b0;
      rd_taken <= 1'b0;
      rxcmd_taken <= 1'b0;
      tx_valid <= 1'b0;
      tx_first <= 1'b0;
      tx_byte <= DATA_RESET;
      tx_done <= 1'b0;
      suspend_exit <= 1'b0;
    end else begin
      rx_taken <= tick & entering_send & sel_rx;
      rd_taken <= tick & entering_send & sel_rd;
      rxcmd_taken <= tick & entering_send & sel_cmd & rxcmd_req;
      tx_valid <= tick & (idle_txcmd | link_byte);
      tx_first <= tick & idle_txcmd;
      if (tick && (idle_txcmd || link_byte)) begin
        tx_byte <= data_s;
      end
      tx_done <= tick & (state == ST_LINK_TX) & stp_s;
      suspend_exit <= lp_wake;
    end
  end

  assign lp.enter = tick & entering_lp;
  assign lp.leave = lp_wake;

  // the link must not drive while direction is high
  assign ulpi_dir = dir;
  assign ulpi_nxt = nxt;
  assign ulpi_data_oe_n = ~dir;
  assign ulpi_data_out = in_lp ? lp.lp_bus : data_reg;
  assign sync_mode = ~in_lp & (state != ST_POWERUP);

endmodule

// ### inc/ulp_pkg.sv
/*
  Shared constants and types of the transceiver-side interface port:
  clock rates, low-power bus layout, reset values and the port state codes.
  Assumes a single system clock and a synchronous, active-high reset.
*/
package ulp_pkg;

  // clock figures, in MHz
  localparam int CLK_MHZ = 250;
  localparam int IFC_CLK_MHZ = 60;
  // half period of the interface clock in system cycles, rounded down
  localparam logic [3:0] CLK_DIV_HALF = 4'(CLK_MHZ / (2 * IFC_CLK_MHZ));
  localparam logic [3:0] DIV_RESET = 4'h0;

  // interface clock edges to wait for the clock to settle after power-up
  localparam logic [7:0] CLK_STABLE_TICKS = 8'h10;
  // turnaround length in interface clock cycles
  localparam logic [1:0] TURN_TICKS = 2'h1;

  // bus widths
  localparam int DATA_W = 8;
  localparam int INT_SRC_W = 5;

  // low-power bus mapping
  localparam int LP_LINE0 = 0;
  localparam int LP_LINE1 = 1;
  localparam int LP_INT = 3;

  // pin values after reset, and the empty transmit command
  localparam logic DIR_RESET = 1'b1;
  localparam logic NXT_RESET = 1'b0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] TXCMD_NONE = 8'h00;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_IDLE = 3'b001,
    ST_LINK_TX = 3'b010,
    ST_TURN_UP = 3'b011,
    ST_SEND = 3'b100,
    ST_TURN_DN = 3'b101,
    ST_LOWPOWER = 3'b110
  } ulp_state_t;

endpackage

// ### inc/ulp_lp_if.sv
/*
  Carrier between the interface port and its low-power helper.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface ulp_lp_if;
  import ulp_pkg::*;
  logic enter;
  logic leave;
  logic [DATA_W-1:0] lp_bus;
  logic wake_rxcmd;

  modport port (
    output enter,
    output leave,
    input lp_bus,
    input wake_rxcmd
  );

  modport lowp (
    input enter,
    input leave,
    output lp_bus,
    output wake_rxcmd
  );
endinterface

// ### hw/ulp_lowpower.sv
/*
  Low-power bus mapping and suspend interrupt tracking.
  Assumes line state comes straight from the analog receiver and the
  interrupt sources come from logic on the system clock.
*/
`timescale 1ns/1ps
module ulp_lowpower (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // analog and interrupt sources
  input wire logic [1:0] line_state,
  input wire logic [ulp_pkg::INT_SRC_W-1:0] int_sources,
  input wire logic [ulp_pkg::INT_SRC_W-1:0] int_enable,
  // port side
  ulp_lp_if.lowp lp
);
  import ulp_pkg::*;

  logic [INT_SRC_W-1:0] snapshot;
  logic changed;
  logic wake_pending;

  wire int_any = |(int_sources & int_enable);
  wire differs = (int_sources != snapshot);

  // no flops on the line state path: it must follow the wire while clocks may be stopped
  assign lp.lp_bus = {4'h0, int_any, 1'b0, line_state[1], line_state[0]};
  assign lp.wake_rxcmd = wake_pending;

  always_ff @(posedge clock) begin
    if (reset) begin
      snapshot <= '0;
      changed <= 1'b0;
      wake_pending <= 1'b0;
    end else begin
      if (lp.enter) begin
        snapshot <= int_sources;
        changed <= 1'b0;
      end else if (differs) begin
        changed <= 1'b1;
      end
      // a change that has gone again by wake-up raises nothing
      wake_pending <= lp.leave ? (changed & differs) : 1'b0;
    end
  end

endmodule

// ### test/ulp_checker.sv
/*
  Pin-level assertions for the interface port.
  Assumes it is bound to ulp_phy_port on the system clock.
*/
`timescale 1ns/1ps
module ulp_checker (
  // system
  input wire logic clock,
  input wire logic reset,
  // pins
  input wire logic ulpi_clock_out,
  input wire logic [ulp_pkg::DATA_W-1:0] ulpi_data_out,
  input wire logic ulpi_data_oe_n,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic ulpi_stp,
  // core side
  input wire logic [1:0] line_state,
  input wire logic [ulp_pkg::INT_SRC_W-1:0] int_sources,
  input wire logic [ulp_pkg::INT_SRC_W-1:0] int_enable,
  input wire logic [ulp_pkg::DATA_W-1:0] rx_data,
  input wire logic rx_taken,
  input wire logic [ulp_pkg::DATA_W-1:0] rxcmd_byte,
  input wire logic rxcmd_taken,
  input wire logic tx_valid,
  input wire logic tx_first,
  input wire logic [ulp_pkg::DATA_W-1:0] tx_byte,
  input wire logic sync_mode
);
  import ulp_pkg::*;
  // power-up also has sync_mode low; only a later drop means suspend
  logic was_up;
  wire lp_now = was_up & ~sync_mode;
  always_ff @(posedge clock) begin
    was_up <= reset ? 1'b0 : (was_up | sync_mode);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence no_take;
    !(rx_taken | rxcmd_taken) [*4];
  endsequence
  oe_follows_a: assert property (ulpi_data_oe_n == ~ulpi_dir)
    else $error("output enable does not follow direction");
  dir_on_tick_a: assert property ($changed(ulpi_dir) |-> $rose(ulpi_clock_out))
    else $error("direction moved off an interface tick");
  turn_quiet_a: assert property ($rose(ulpi_dir) |-> no_take)
    else $error("byte sent in turnaround");
  // the core may move its offer right after taken, so compare what it offered at the tick
  rx_byte_a: assert property (rx_taken |->
    ulpi_dir && ulpi_nxt && ulpi_data_out == $past(rx_data))
    else $error("receive byte wrong");
  status_byte_a: assert property (rxcmd_taken |->
    ulpi_dir && !ulpi_nxt && ulpi_data_out == $past(rxcmd_byte))
    else $error("status byte wrong");
  abort_drop_a: assert property (sync_mode && ulpi_dir && ulpi_stp |->
    ##[1:12] !ulpi_dir)
    else $error("abort did not release direction");
  tx_cmd_a: assert property (tx_first |-> tx_valid && tx_byte != TXCMD_NONE)
    else $error("zero transmit command taken");
  tx_paced_a: assert property (tx_valid && !tx_first |-> $past(ulpi_nxt, 2))
    else $error("byte taken without next");
  lp_pins_a: assert property (!sync_mode |-> ulpi_dir && !ulpi_nxt)
    else $error("direction or next wrong in low power");
  lp_map_a: assert property (lp_now |->
    ulpi_data_out == {4'h0, |(int_sources & int_enable), 1'h0, line_state})
    else $error("low power bus mapping wrong");
endmodule
bind ulp_phy_port ulp_checker u_chk (.clock, .reset, .ulpi_clock_out, .ulpi_data_out,
  .ulpi_data_oe_n, .ulpi_dir, .ulpi_nxt, .ulpi_stp, .line_state, .int_sources, .int_enable,
  .rx_data, .rx_taken, .rxcmd_byte, .rxcmd_taken, .tx_valid, .tx_first, .tx_byte, .sync_mode);

// ### test/ulp_link_model.sv
/*
  Behavioural link controller on the far side of the pins.
  Assumes the port sources the interface clock and owns direction.
*/
`timescale 1ns/1ps
module ulp_link_model (
  // pins seen
  input wire logic clock,
  input wire logic ulpi_clock_out,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  // pins driven
  output logic [ulp_pkg::DATA_W-1:0] ulpi_data_in,
  output logic ulpi_stp
);
  import ulp_pkg::*;
  logic busy = 1'b0;
  initial ulpi_stp = 1'b0;
  initial ulpi_data_in = DATA_RESET;
  // released bus toggles so a stale byte never looks valid
  always @(negedge clock) begin
    if (ulpi_dir)
      ulpi_data_in <= ~ulpi_data_in;
    else if (!busy)
      ulpi_data_in <= TXCMD_NONE;
  end
  task automatic wait_cycle();
    @(posedge ulpi_clock_out);
    @(negedge clock);
  endtask
  task automatic send_packet(input logic [7:0] pkt[$]);
    int idx;
    idx = 0;
    busy = 1'b1;
    wait_cycle();
    ulpi_data_in <= pkt[0];
    for (int k = 0; k < 64 && idx < pkt.size(); k++) begin
      wait_cycle();
      if (ulpi_nxt) begin
        idx++;
        ulpi_data_in <= (idx < pkt.size()) ? pkt[idx] : TXCMD_NONE;
        ulpi_stp <= (idx == pkt.size());
      end
    end
    wait_cycle();
    ulpi_stp <= 1'b0;
    busy = 1'b0;
  endtask
  // reference clock is never stopped here, so waking is always legal
  task automatic hold_stop();
    @(negedge clock);
    ulpi_stp <= 1'b1;
    for (int k = 0; k < 64 && ulpi_dir; k++) @(negedge clock);
    ulpi_stp <= 1'b0;
  endtask
endmodule

// ### test/testbench.sv
/*
  Self-checking bench for ulp_phy_port with a behavioural link.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ps
module testbench;
  import ulp_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic osc_present, ulpi_clock_out, ulpi_data_oe_n, ulpi_dir, ulpi_nxt, ulpi_stp;
  logic [DATA_W-1:0] ulpi_data_in, ulpi_data_out, rx_data, rxcmd_byte, rd_data, tx_byte;
  logic [1:0] line_state;
  logic [INT_SRC_W-1:0] int_sources, int_enable;
  logic rx_active, rx_valid, rx_taken, rxcmd_req, rxcmd_taken, rd_valid, rd_taken;
  logic tx_ready, tx_valid, tx_first, tx_done, suspend_bar_bit, suspend_exit, sync_mode;
  logic stall = 1'b0;
  logic [7:0] q_tx[$];
  logic [7:0] q_up[$];
  int failures, cmp_count, rx_left, ticks, exits, dones;
  integer seed = 23;
  ulp_phy_port u_dut (.clock, .reset, .osc_present, .ulpi_clock_out, .ulpi_data_in,
    .ulpi_data_out, .ulpi_data_oe_n, .ulpi_dir, .ulpi_nxt, .ulpi_stp, .line_state,
    .int_sources, .int_enable, .rx_active, .rx_valid, .rx_data, .rx_taken, .rxcmd_req,
    .rxcmd_byte, .rxcmd_taken, .rd_valid, .rd_data, .rd_taken, .tx_ready, .tx_valid,
    .tx_first, .tx_byte, .tx_done, .suspend_bar_bit, .suspend_exit, .sync_mode);
  ulp_link_model u_link (.clock, .ulpi_clock_out, .ulpi_dir, .ulpi_nxt, .ulpi_data_in,
    .ulpi_stp);
  always #2 clock = ~clock;
  always @(posedge ulpi_clock_out) ticks++;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // results are matched against the oldest note as they appear
  always @(negedge clock) begin
    if (tx_valid) check("tx_byte", tx_byte, q_tx.size() ? q_tx.pop_front() : 8'hXX);
    if (rx_taken | rd_taken | rxcmd_taken)
      check("bus_byte", ulpi_data_out, q_up.size() ? q_up.pop_front() : 8'hXX);
    if (suspend_exit) exits++;
    if (tx_done) dones++;
    if (stall) tx_ready = 1'($random(seed));
    if (rd_taken) rd_valid = 1'b0;
    if (rxcmd_taken) rxcmd_req = 1'b0;
    if (rx_taken) begin
      rx_left--;
      rx_valid = (rx_left != 0);
      rx_active = (rx_left != 0);
      rx_data = 8'($random(seed));
      if (rx_left != 0) q_up.push_back(rx_data);
    end
  end
  initial begin
    #40000;
    failures++;
    complete_run();
  end
  initial begin
    int i;
    logic [7:0] pkt[$];
    {osc_present, tx_ready, suspend_bar_bit, int_enable} = 8'hFF;
    {rx_active, rx_valid, rxcmd_req, rd_valid, line_state, int_sources} = 10'h000;
    {rx_data, rxcmd_byte, rd_data} = 24'h000000;
    repeat (5) @(negedge clock);
    reset = 1'b0;
    for (i = 0; i < 400 && ulpi_dir; i++) @(negedge clock);
    check("sync_mode", 8'(sync_mode), 8'h01);
    i = ticks;
    repeat (40) @(negedge clock);
    check("clock_ticks", 8'(ticks - i), 8'h0A);
    $display("test startup done");
    stall = 1'b1;
    pkt = {8'h40 | 8'($random(seed))};
    repeat (4) pkt.push_back(8'($random(seed)));
    foreach (pkt[k]) q_tx.push_back(pkt[k]);
    u_link.send_packet(pkt);
    stall = 1'b0;
    tx_ready = 1'b1;
    repeat (8) @(negedge clock);
    check("tx_done", 8'(dones), 8'h01);
    check("tx_left", 8'(q_tx.size()), 8'h00);
    $display("test link_tx done");
    rd_data = 8'($random(seed));
    rxcmd_byte = 8'($random(seed));
    q_up = {rd_data, rxcmd_byte};
    {rd_valid, rxcmd_req} = 2'h3;
    for (i = 0; i < 100 && (rxcmd_req || ulpi_dir); i++) @(negedge clock);
    check("send_left", 8'(q_up.size()), 8'h00);
    check("dir_idle", 8'(ulpi_dir), 8'h00);
    rx_left = 4;
    rx_data = 8'($random(seed));
    q_up.push_back(rx_data);
    {rx_active, rx_valid} = 2'h3;
    for (i = 0; i < 100 && (rx_active || ulpi_dir); i++) @(negedge clock);
    check("rx_left", 8'(q_up.size()), 8'h00);
    $display("test send done");
    rx_active = 1'b1;
    for (i = 0; i < 40 && !ulpi_dir; i++) @(negedge clock);
    repeat (8) @(negedge clock);
    u_link.hold_stop();
    rx_active = 1'b0;
    repeat (12) @(negedge clock);
    check("abort_dir", 8'(ulpi_dir), 8'h00);
    $display("test abort done");
    suspend_bar_bit = 1'b0;
    for (i = 0; i < 60 && sync_mode; i++) @(negedge clock);
    line_state = 2'($random(seed));
    int_sources = 5'h04;
    repeat (2) @(negedge clock);
    check("lp_bus", ulpi_data_out, {4'h0, 1'h1, 1'h0, line_state});
    check("lp_pins", 8'({ulpi_dir, ulpi_nxt}), 8'h02);
    suspend_bar_bit = 1'b1;
    rxcmd_byte = 8'($random(seed));
    u_link.hold_stop();
    for (i = 0; i < 60 && !ulpi_dir; i++) @(negedge clock);
    repeat (4) @(negedge clock);
    check("wake_status", ulpi_data_out, rxcmd_byte);
    check("wake_exit", 8'(exits), 8'h01);
    $display("test low_power done");
    complete_run();
  end
endmodule
